// [test/mcr_top_chk.sv]
// Purpose: bus, select and clock ratio checks for the misc control block
// Assumes: one clock aclk, synchronous active-low reset aresetn
// Notes: only high phases are timed; low phases stretch around reset
module mcr_top_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic irq_mask_flag,
    input wire logic slave_select_pin_n,
    input wire logic spi_slave_select_n,
    input wire logic port_b_line_two_gpio,
    input wire logic periph_clk,
    input wire logic cpu_clk,
    input wire mcr_pkg::mcr_sense_t port_a_irq_sense,
    input wire mcr_pkg::mcr_sense_t port_b_irq_sense
);
    import mcr_pkg::*;
    logic pc_last_r;
    logic cc_last_r;
    logic [4:0] pc_run_r;
    logic [4:0] cc_run_r;
    // run counters hold the length of the current phase minus one
    always_ff @(posedge aclk) begin
        pc_last_r <= periph_clk;
        cc_last_r <= cpu_clk;
        pc_run_r <= (periph_clk != pc_last_r) ? 5'h0 : pc_run_r + 5'h1;
        cc_run_r <= (cpu_clk != cc_last_r) ? 5'h0 : cc_run_r + 5'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sense_a_guard_a: assert property (
        $changed(port_a_irq_sense) |-> $past(irq_mask_flag))
        else $error("port a sense moved while unmasked");
    sense_b_guard_a: assert property (
        $changed(port_b_irq_sense) |-> $past(irq_mask_flag))
        else $error("port b sense moved while unmasked");
    ss_pin_follow_a: assert property (
        !$past(port_b_line_two_gpio)
        |-> spi_slave_select_n == $past(slave_select_pin_n, 3))
        else $error("select does not follow pin");
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    aw_block_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    ar_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during data");
    pclk_phase_a: assert property (
        pc_last_r && !periph_clk |-> pc_run_r <= 5'h1)
        else $error("peripheral clock high phase wrong");
    cclk_phase_a: assert property (
        cc_last_r && !cpu_clk |-> cc_run_r == 5'h0 || cc_run_r == 5'hf)
        else $error("cpu clock high phase wrong");
endmodule : mcr_top_chk

bind mcr_top mcr_top_chk mcr_top_chk_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .irq_mask_flag, .slave_select_pin_n,
    .spi_slave_select_n, .port_b_line_two_gpio, .periph_clk, .cpu_clk,
    .port_a_irq_sense, .port_b_irq_sense
);

// [test/mcr_top_tb.sv]
// Purpose: self-checking bench for the misc control register block
// Assumes: AXI4-Lite master tasks, 250 MHz aclk, pins idle high
// Notes: irq and clock activity is counted over fixed windows
module mcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcr_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, mask = 1'b1, ss_pin = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [7:0] pa_pins = 8'hff, pa_dir = 8'h00, pa_opt = 8'h00;
    logic [5:0] pb_pins = 6'h3f, pb_dir = 6'h00, pb_opt = 6'h00;
    logic awready, wready, bvalid, arready, rvalid;
    logic ss_n, gpio, irq_a, irq_b, pclk, cclk;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    mcr_sense_t sense_a, sense_b;
    int mismatches = 0, comparisons = 0, na, nb, np, nc;
    int e[4] = '{4, 1, 1, 2};

    mcr_top mcr_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_mask_flag(mask),
        .port_a_pins(pa_pins), .port_a_dir(pa_dir), .port_a_opt(pa_opt),
        .port_b_pins(pb_pins), .port_b_dir(pb_dir), .port_b_opt(pb_opt),
        .slave_select_pin_n(ss_pin), .spi_slave_select_n(ss_n),
        .port_b_line_two_gpio(gpio), .port_a_ext_irq(irq_a),
        .port_b_ext_irq(irq_b), .periph_clk(pclk), .cpu_clk(cclk),
        .port_a_irq_sense(sense_a), .port_b_irq_sense(sense_b)
    );

    always #2 aclk = ~aclk;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] got);
        comparisons++;
        if (got !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, x, got);
        end
    endtask : chk

    task automatic hold_on(input logic ok);
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR bus answer expected 1 seen %b", ok);
            close_out();
        end
    endtask : hold_on

    // address and data go out together; each drops once taken
    task automatic wx(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        hold_on(aw_ok && w_ok);
        do begin
            @(posedge aclk);
            n++;
        end while (!bvalid && n < 200);
        hold_on(bvalid);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : wx

    task automatic rx(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 100);
        hold_on(arready);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rvalid && n < 200);
        hold_on(rvalid);
        chk("rdata", x, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask : rx

    task automatic watch(input int cyc);
        logic pp;
        logic pc;
        pp = pclk;
        pc = cclk;
        {na, nb, np, nc} = 128'h0;
        repeat (cyc) begin
            @(posedge aclk);
            na += int'(irq_a);
            nb += int'(irq_b);
            np += int'(pclk && !pp);
            nc += int'(cclk && !pc);
            pp = pclk;
            pc = cclk;
        end
    endtask : watch

    // one pin low for four cycles, watched over the whole response
    task automatic pulse(input logic on_b);
        fork
            watch(16);
            begin
                if (on_b) pb_pins[3] <= 1'b0;
                else pa_pins[0] <= 1'b0;
                repeat (4) @(posedge aclk);
                pa_pins <= 8'hff;
                pb_pins <= 6'h3f;
            end
        join
    endtask : pulse

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rx(8'h20, 32'h0, 2'h0);
        chk("ss_n", 1, ss_n);
        wx(8'h20, 32'hff, 4'hf, 2'h0);
        rx(8'h20, 32'hff, 2'h0);
        chk("gpio", 1, gpio);
        chk("ss_n soft", 1, ss_n);
        wx(8'h20, 32'h40, 4'hf, 2'h0);
        @(negedge aclk);
        chk("ss_n soft", 0, ss_n);
        wx(8'h20, 32'h0, 4'hf, 2'h0);
        @(posedge aclk);
        ss_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("ss_n pin", 0, ss_n);
        chk("gpio", 0, gpio);
        @(posedge aclk);
        ss_pin <= 1'b1;
        wx(8'h24, 32'h5a, 4'hf, 2'h2);
        wx(8'h20, 32'h5a, 4'h0, 2'h0);
        rx(8'h24, 32'h0, 2'h2);
        rx(8'h23, 32'h0, 2'h0);
        pa_opt <= 8'h01;
        pb_opt <= 6'h08;
        for (int m = 0; m < 4; m++) begin
            wx(8'h20, {27'h0, 2'(3 - m), m[1:0], 1'b0}, 4'hf, 2'h0);
            chk("sense_a", m, sense_a);
            chk("sense_b", 3 - m, sense_b);
            pulse(1'b0);
            chk("irq_a", e[m], na);
            chk("irq_b idle", 0, nb);
            pulse(1'b1);
            chk("irq_b", e[3 - m], nb);
            chk("irq_a idle", 0, na);
        end
        for (int q = 0; q < 2; q++) begin
            pa_dir <= {7'h0, q[0]};
            pa_opt <= {7'h0, q[0]};
            pulse(1'b0);
            chk("irq_a off", 0, na);
        end
        mask <= 1'b0;
        wx(8'h20, 32'he1, 4'hf, 2'h0);
        // sense bits keep 0x06 from the last mode; the rest is written
        rx(8'h20, 32'he7, 2'h0);
        mask <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            // aclk over four keeps the peripheral clock slow
            wx(8'h20, {24'h0, k[1], 6'h0, k[0]}, 4'hf, 2'h0);
            repeat (40) @(posedge aclk);
            watch(64);
            chk("pclk rises", k[1] ? 16 : 32, np);
            chk("cclk rises", k[0] ? 2 : 32, nc);
        end
        close_out();
    end
endmodule : mcr_top_tb

// [verilog/mcr_clk_div.sv]
// Purpose: glitch-free two-ratio clock divider
// Assumes: half periods fit CNT_W bits and are at least one cycle
// Notes: a new ratio is taken only at the end of a whole period
`include "mcr_defines.svh"
module mcr_clk_div #(
    parameter int CNT_W = 5,
    parameter logic [CNT_W-1:0] HALF_A = 5'd1,
    parameter logic [CNT_W-1:0] HALF_B = 5'd2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sel,
    output logic clk_out
);
    initial begin
        if (HALF_A == 0 || HALF_B == 0) $error("mcr_clk_div: zero half");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic out;
        logic cur;
    } mcr_div_st_t;

    mcr_div_st_t st_r;
    mcr_div_st_t st_nxt;
    logic [CNT_W-1:0] half;

    assign half = st_r.cur ? HALF_B : HALF_A;

    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt == half - 1'b1) begin
            st_nxt.cnt = '0;
            st_nxt.out = ~st_r.out;
            // switch only as the high phase ends: no short pulse
            if (st_r.out) begin
                st_nxt.cur = sel;
            end
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_out = st_r.out;

endmodule : mcr_clk_div

// [verilog/mcr_defines.svh]
// Purpose: offsets, field positions, reset values and divider counts
// Assumes: register bus with 32-bit data, one aligned word per register
// Notes: included by the misc control block and its clock divider
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

`define MCR_MISC_OFF 32'h0000_0020
`define MCR_MISC_RST 8'h00

`define MCR_BIT_PCLK_DIV 7
`define MCR_BIT_SS_SRC 6
`define MCR_BIT_SS_SOFT 5
`define MCR_PB_SENSE_HI 4
`define MCR_PB_SENSE_LO 3
`define MCR_PA_SENSE_HI 2
`define MCR_PA_SENSE_LO 1
`define MCR_BIT_SLOW 0

// half periods in aclk cycles (oscillator clock is aclk)
`define MCR_PCLK_HALF_NORM 5'd1
`define MCR_PCLK_HALF_ALT 5'd2
`define MCR_CPU_HALF_NORM 5'd1
`define MCR_CPU_HALF_SLOW 5'd16

`define MCR_RESP_OKAY 2'h0
`define MCR_RESP_SLVERR 2'h2

`endif

// [verilog/mcr_ext_irq.sv]
// Purpose: external interrupt detector for one port
// Assumes: pin inputs already pass two flip-flops in the parent
// Notes: request is a registered level; edges give one-cycle pulses
module mcr_ext_irq #(
    parameter int N = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] pin_s,
    input wire logic [N-1:0] irq_en,
    mcr_sense_if.det sif
);
    import mcr_pkg::*;

    initial begin
        if (N < 1 || N > 8) $error("mcr_ext_irq: N must be 1..8");
    end

    typedef struct packed {
        logic [N-1:0] prev;
        logic req;
    } mcr_irq_st_t;

    mcr_irq_st_t st_r;
    mcr_irq_st_t st_nxt;
    logic [N-1:0] fall;
    logic [N-1:0] rise;
    logic [N-1:0] low;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            // compare current sample with previous one
            assign fall[g] = irq_en[g] & st_r.prev[g] & ~pin_s[g];
            assign rise[g] = irq_en[g] & ~st_r.prev[g] & pin_s[g];
            assign low[g] = irq_en[g] & ~pin_s[g];
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pin_s;
        case (sif.sense)
            MCR_SENSE_FALL_LOW: st_nxt.req = |fall | |low;
            MCR_SENSE_RISE: st_nxt.req = |rise;
            MCR_SENSE_FALL: st_nxt.req = |fall;
            MCR_SENSE_BOTH: st_nxt.req = |fall | |rise;
            default: st_nxt.req = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // pins idle high, so no edge is seen right after reset
            st_r <= '{prev: {N{1'b1}}, req: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sif.req = st_r.req;

endmodule : mcr_ext_irq

// [verilog/mcr_pkg.sv]
// Purpose: shared types of the misc control block
// Assumes: nothing beyond the defines header
// Notes: sense encodings follow the control register layout
package mcr_pkg;

    typedef enum logic [1:0] {
        MCR_SENSE_FALL_LOW = 2'h0,
        MCR_SENSE_RISE = 2'h1,
        MCR_SENSE_FALL = 2'h2,
        MCR_SENSE_BOTH = 2'h3
    } mcr_sense_t;

endpackage : mcr_pkg

// [verilog/mcr_sense_if.sv]
// Purpose: carries one interrupt source's sensitivity and its request
// Assumes: single clock domain
// Notes: ctl end owns the setting, det end owns the request
interface mcr_sense_if;
    import mcr_pkg::*;
    mcr_sense_t sense;
    logic req;
    modport ctl (output sense, input req);
    modport det (input sense, output req);
endinterface : mcr_sense_if

// [verilog/mcr_top.sv]
// Purpose: misc control register with interrupt sense, slave-select
//          source and clock ratio selection, on an AXI4-Lite slave
// Assumes: aclk is the oscillator clock; irq_mask_flag comes from the
//          cpu on aclk; port pins and the select pin are asynchronous
// Notes: one register word; all other addresses answer SLVERR
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "mcr_defines.svh"
module mcr_top #(
    parameter int ADDR_W = 8,
    parameter int PA_N = 8,
    parameter int PB_N = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_mask_flag,
    input wire logic [PA_N-1:0] port_a_pins,
    input wire logic [PA_N-1:0] port_a_dir,
    input wire logic [PA_N-1:0] port_a_opt,
    input wire logic [PB_N-1:0] port_b_pins,
    input wire logic [PB_N-1:0] port_b_dir,
    input wire logic [PB_N-1:0] port_b_opt,
    input wire logic slave_select_pin_n,
    output logic spi_slave_select_n,
    output logic port_b_line_two_gpio,
    output logic port_a_ext_irq,
    output logic port_b_ext_irq,
    output logic periph_clk,
    output logic cpu_clk,
    output mcr_pkg::mcr_sense_t port_a_irq_sense,
    output mcr_pkg::mcr_sense_t port_b_irq_sense
);
    import mcr_pkg::*;

    initial begin
        if (ADDR_W < 6 || ADDR_W > 32) $error("mcr_top: ADDR_W 6..32");
        if (PA_N < 1 || PA_N > 8) $error("mcr_top: PA_N 1..8");
        if (PB_N < 3 || PB_N > 8) $error("mcr_top: PB_N 3..8");
    end

    localparam logic [ADDR_W-1:0] MISC_ADDR = ADDR_W'(`MCR_MISC_OFF);

    function automatic logic is_misc(input logic [ADDR_W-1:0] a);
        // byte address bits 1:0 are ignored, the word is what counts
        return a[ADDR_W-1:2] == MISC_ADDR[ADDR_W-1:2];
    endfunction : is_misc

    typedef struct packed {
        logic [7:0] misc_control_reg;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [PA_N-1:0] pa_s1;
        logic [PA_N-1:0] pa_s2;
        logic [PB_N-1:0] pb_s1;
        logic [PB_N-1:0] pb_s2;
        logic ss_s1;
        logic ss_s2;
        logic ss_out_n;
    } mcr_st_t;

    mcr_st_t st_r;
    mcr_st_t st_nxt;
    logic [7:0] wr_val;
    logic pclk_sel;
    logic slow_clock_select;
    logic slave_select_source_sel;
    logic slave_select_soft_level;

    mcr_sense_if pa_if ();
    mcr_sense_if pb_if ();

    assign pclk_sel = st_r.misc_control_reg[`MCR_BIT_PCLK_DIV];
    assign slave_select_source_sel = st_r.misc_control_reg[`MCR_BIT_SS_SRC];
    assign slave_select_soft_level = st_r.misc_control_reg[`MCR_BIT_SS_SOFT];
    assign slow_clock_select = st_r.misc_control_reg[`MCR_BIT_SLOW];

    // independent fields, one per source
    assign pb_if.sense = mcr_sense_t'(st_r.misc_control_reg[
        `MCR_PB_SENSE_HI:`MCR_PB_SENSE_LO]);
    assign pa_if.sense = mcr_sense_t'(st_r.misc_control_reg[
        `MCR_PA_SENSE_HI:`MCR_PA_SENSE_LO]);

    // sense fields keep their old value unless interrupts are masked
    always_comb begin
        wr_val = st_r.w_byte;
        if (!irq_mask_flag) begin
            wr_val[`MCR_PB_SENSE_HI:`MCR_PB_SENSE_LO] =
                st_r.misc_control_reg[`MCR_PB_SENSE_HI:`MCR_PB_SENSE_LO];
            wr_val[`MCR_PA_SENSE_HI:`MCR_PA_SENSE_LO] =
                st_r.misc_control_reg[`MCR_PA_SENSE_HI:`MCR_PA_SENSE_LO];
        end
    end

    always_comb begin
        st_nxt = st_r;
        // two-stage synchronisers; stage one feeds only stage two
        st_nxt.pa_s1 = port_a_pins;
        st_nxt.pa_s2 = st_r.pa_s1;
        st_nxt.pb_s1 = port_b_pins;
        st_nxt.pb_s2 = st_r.pb_s1;
        st_nxt.ss_s1 = slave_select_pin_n;
        st_nxt.ss_s2 = st_r.ss_s1;
        st_nxt.ss_out_n = slave_select_source_sel ?
            slave_select_soft_level : st_r.ss_s2;

        // write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_byte = s_axi_wdata[7:0];
            st_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            if (is_misc(st_r.aw_addr)) begin
                st_nxt.bresp = `MCR_RESP_OKAY;
                if (st_r.w_lane0) begin
                    st_nxt.misc_control_reg = wr_val;
                end
            end else begin
                st_nxt.bresp = `MCR_RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            if (is_misc(s_axi_araddr)) begin
                st_nxt.rdata = st_r.misc_control_reg;
                st_nxt.rresp = `MCR_RESP_OKAY;
            end else begin
                st_nxt.rdata = 8'h00;
                st_nxt.rresp = `MCR_RESP_SLVERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.misc_control_reg <= `MCR_MISC_RST;
            // select pin idles high (inactive)
            st_r.ss_s1 <= 1'b1;
            st_r.ss_s2 <= 1'b1;
            st_r.ss_out_n <= 1'b1;
            st_r.pa_s1 <= '1;
            st_r.pa_s2 <= '1;
            st_r.pb_s1 <= '1;
            st_r.pb_s2 <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a pin is an interrupt input only as input with option set
    mcr_ext_irq #(.N(PA_N)) u_irq_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_s(st_r.pa_s2),
        .irq_en(~port_a_dir & port_a_opt),
        .sif(pa_if.det)
    );

    mcr_ext_irq #(.N(PB_N)) u_irq_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_s(st_r.pb_s2),
        .irq_en(~port_b_dir & port_b_opt),
        .sif(pb_if.det)
    );

    // peripheral clock ratio; staying under 4 MHz is up to software
    mcr_clk_div #(
        .CNT_W(5),
        .HALF_A(`MCR_PCLK_HALF_NORM),
        .HALF_B(`MCR_PCLK_HALF_ALT)
    ) u_pclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(pclk_sel),
        .clk_out(periph_clk)
    );

    mcr_clk_div #(
        .CNT_W(5),
        .HALF_A(`MCR_CPU_HALF_NORM),
        .HALF_B(`MCR_CPU_HALF_SLOW)
    ) u_cpuclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(slow_clock_select),
        .clk_out(cpu_clk)
    );

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = {24'h000000, st_r.rdata};

    assign spi_slave_select_n = st_r.ss_out_n;
    // shared line is free for plain I/O under software select
    assign port_b_line_two_gpio = slave_select_source_sel;
    assign port_a_ext_irq = pa_if.req;
    assign port_b_ext_irq = pb_if.req;
    assign port_a_irq_sense = pa_if.sense;
    assign port_b_irq_sense = pb_if.sense;

endmodule : mcr_top
